// *** voice_channel_command_decoder.sv ***
// Command decoder for the two-channel line interface host port
// Behaviour
// RQ1: Even code writes a register, next odd code reads; bit 0 set means read.
// RQ2: Software reset acts only on channels whose enable bits are set.
// RQ3: Software reset keeps time slots, clock slots and chip-wide settings.
// RQ4: Software reset puts selected channels in disconnect unless in shutdown.
// RQ5: Hardware reset command acts exactly like the reset pin held low.
// RQ6: Hardware reset ignores channel enables and shuts down every channel.
// RQ7: Any hardware reset restores every register field to its default.
// RQ8: Host writes zero to reserved bits; reserved read value is unspecified.
// RQ9: Host never sends a code missing from the command list.
// RQ10: Channel enable register is chip-wide, reachable under any enables.
// RQ11: Read-only chip command returns revision and product code; the code returns their XOR as one byte.
// RQ12: Read-only channel command returns transmit sample data; no write.
// RQ13: Transmit time slot is stored per channel, reached via enables.
// RQ14: Clock slot and edge register is one chip-wide register.
// RQ15: Interrupt mask register is one chip-wide register.
// RQ16: Switching regulator parameter and control registers are chip-wide.
// RQ17: No-operation completes and changes nothing, including pending read data.
// RQ18: Channel writes with several enables update all enabled channels alike.
// RQ19: Channel reads with several enables return the lowest enabled channel.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_map.svh"
module voice_channel_command_decoder
  import cmd_decoder_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_in,
  input  wire logic       rd_taken,
  input  wire logic [7:0] tx_sample_0,
  input  wire logic [7:0] tx_sample_1,
  output logic            rd_valid,
  output logic      [7:0] rd_data,
  output logic            busy,
  output logic      [1:0] chan_shutdown,
  output logic      [1:0] chan_enable,
  output logic            hard_reset_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dec_state_type state_reg, state_next;
  logic [7:0]    cmd_reg, cmd_next;
  logic [7:0]    rdat_reg, rdat_next;
  logic          rval_reg, rval_next;
  logic          hrst_reg, hrst_next;
  logic          soft_reg, soft_next;
  logic          wstb_reg, wstb_next;
  logic [7:0]    wdat_reg, wdat_next;
  logic [7:0]    chan_en_reg, chan_en_next;
  logic [7:0]    clk_slot_reg, clk_slot_next;
  logic [7:0]    dev_cfg_reg, dev_cfg_next;
  logic [7:0]    int_mask_reg, int_mask_next;
  logic [7:0]    swreg_par_reg, swreg_par_next;
  logic [7:0]    swreg_ctl_reg, swreg_ctl_next;
  logic [1:0]    shut_reg, shut_next;
  logic          busy_reg, busy_next;

  logic [7:0]     tx_slot [2];
  logic [7:0]     rx_slot [2];
  logic [7:0]     gains   [2];
  line_state_type lstate  [2];
  logic [1:0]     sel;
  logic           low_ch;
  logic [7:0]     tx_sample;

  assign sel       = {chan_en_reg[`CHAN1_EN_BIT], chan_en_reg[`CHAN0_EN_BIT]};
  // RQ19: lowest enabled channel wins
  assign low_ch    = !sel[0] && sel[1];
  assign tx_sample = low_ch ? tx_sample_1 : tx_sample_0;

  // ----------------------------------------------------------------
  // Per-channel register sets
  // ----------------------------------------------------------------
  channel_regs #(
    .TX_SLOT_RST (`TX_SLOT_RST0),
    .RX_SLOT_RST (`RX_SLOT_RST0)
  ) u_chan0 (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .hard_reset (hrst_reg),
    .selected   (sel[0]),
    .soft_reset (soft_reg),
    .wr_stb     (wstb_reg),
    .wr_cmd     (cmd_reg),
    .wr_data    (wdat_reg),
    .tx_slot    (tx_slot[0]),
    .rx_slot    (rx_slot[0]),
    .gains      (gains[0]),
    .line_state (lstate[0])
  );

  channel_regs #(
    .TX_SLOT_RST (`TX_SLOT_RST1),
    .RX_SLOT_RST (`RX_SLOT_RST1)
  ) u_chan1 (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .hard_reset (hrst_reg),
    .selected   (sel[1]),
    .soft_reset (soft_reg),
    .wr_stb     (wstb_reg),
    .wr_cmd     (cmd_reg),
    .wr_data    (wdat_reg),
    .tx_slot    (tx_slot[1]),
    .rx_slot    (rx_slot[1]),
    .gains      (gains[1]),
    .line_state (lstate[1])
  );

  // ----------------------------------------------------------------
  // Decoder: command byte, then one data byte in or out
  // ----------------------------------------------------------------
  // Channel resets are pipelined one cycle behind the command so the
  // channel sets see a single clean strobe.
  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    rdat_next      = rdat_reg;
    rval_next      = rval_reg;
    hrst_next      = 1'b0;
    soft_next      = 1'b0;
    wstb_next      = 1'b0;
    wdat_next      = wdat_reg;
    chan_en_next   = chan_en_reg;
    clk_slot_next  = clk_slot_reg;
    dev_cfg_next   = dev_cfg_reg;
    int_mask_next  = int_mask_reg;
    swreg_par_next = swreg_par_reg;
    swreg_ctl_next = swreg_ctl_reg;
    shut_next      = {lstate[1] == LINE_SHUTDOWN, lstate[0] == LINE_SHUTDOWN};
    if (hrst_reg) begin
      // RQ5: same as reset pin
      // RQ7: chip-wide defaults
      state_next     = DEC_IDLE;
      cmd_next       = 8'h00;
      rdat_next      = 8'h00;
      rval_next      = 1'b0;
      chan_en_next   = `CHAN_EN_RST;
      clk_slot_next  = `CLK_SLOT_RST;
      dev_cfg_next   = `DEV_CFG_RST;
      int_mask_next  = `INT_MASK_RST;
      swreg_par_next = `SWREG_PAR_RST;
      swreg_ctl_next = `SWREG_CTL_RST;
    end else begin
      case (state_reg)
        DEC_IDLE: begin
          if (byte_valid) begin
            cmd_next = byte_in;
            // RQ1: bit 0 picks direction
            if (byte_in[`RW_BIT]) begin
              state_next = DEC_RD_DATA;
              rval_next  = 1'b1;
              // RQ19 RQ8: lowest channel read, reserved bits zero
              case (byte_in)
                `CMD_TX_SLOT_WR + 8'h01: rdat_next = tx_slot[low_ch];
                `CMD_RX_SLOT_WR + 8'h01: rdat_next = rx_slot[low_ch];
                `CMD_GAINS_WR + 8'h01: rdat_next = gains[low_ch];
                `CMD_SYS_STATE_WR + 8'h01: rdat_next = {6'h00, lstate[low_ch]};
                `CMD_CLK_SLOT_WR + 8'h01: rdat_next = clk_slot_reg;
                `CMD_DEV_CFG_WR + 8'h01: rdat_next = dev_cfg_reg;
                `CMD_CHAN_EN_WR + 8'h01: rdat_next = chan_en_reg;
                `CMD_INT_MASK_WR + 8'h01: rdat_next = int_mask_reg;
                `CMD_SWREG_PAR_WR + 8'h01: rdat_next = swreg_par_reg;
                `CMD_SWREG_CTL_WR + 8'h01: rdat_next = swreg_ctl_reg;
                // RQ11: identity read
                `CMD_REV_RD: rdat_next = `REVISION_ID ^ `PART_CODE_ID;
                // RQ12: transmit sample read
                `CMD_TX_DATA_RD: rdat_next = tx_sample;
                default: rdat_next = 8'h00;
              endcase
            end else begin
              case (byte_in)
                // RQ5: hardware reset command
                `CMD_HARD_RESET: hrst_next = 1'b1;
                // RQ2: software reset on enables
                `CMD_SOFT_RESET: soft_next = 1'b1;
                // RQ17: no-op changes nothing
                `CMD_NO_OP: state_next = DEC_IDLE;
                default: state_next = DEC_WR_DATA;
              endcase
            end
          end
        end
        DEC_WR_DATA: begin
          if (byte_valid) begin
            state_next = DEC_IDLE;
            case (cmd_reg)
              // RQ10: chip-wide enables
              `CMD_CHAN_EN_WR: chan_en_next = byte_in;
              // RQ14: shared clock slot
              `CMD_CLK_SLOT_WR: clk_slot_next = byte_in;
              `CMD_DEV_CFG_WR: dev_cfg_next = byte_in;
              // RQ15: chip-wide mask
              `CMD_INT_MASK_WR: int_mask_next = byte_in;
              // RQ16: chip-wide regulator
              `CMD_SWREG_PAR_WR: swreg_par_next = byte_in;
              `CMD_SWREG_CTL_WR: swreg_ctl_next = byte_in;
              // RQ18: broadcast to all enabled
              default: begin
                wstb_next = 1'b1;
                wdat_next = byte_in;
              end
            endcase
          end
        end
        DEC_RD_DATA: begin
          // No new command until the answer has been taken
          if (rd_taken) begin
            rval_next  = 1'b0;
            state_next = DEC_IDLE;
          end
        end
        default: state_next = DEC_IDLE;
      endcase
    end
    // Busy is registered so the pin comes straight from a flop
    busy_next = state_next != DEC_IDLE;
  end

  // Registers; the pin reset gives the same defaults as the command
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= DEC_IDLE;
      cmd_reg       <= 8'h00;
      rdat_reg      <= 8'h00;
      rval_reg      <= 1'b0;
      hrst_reg      <= 1'b0;
      soft_reg      <= 1'b0;
      wstb_reg      <= 1'b0;
      wdat_reg      <= 8'h00;
      chan_en_reg   <= `CHAN_EN_RST;
      clk_slot_reg  <= `CLK_SLOT_RST;
      dev_cfg_reg   <= `DEV_CFG_RST;
      int_mask_reg  <= `INT_MASK_RST;
      swreg_par_reg <= `SWREG_PAR_RST;
      swreg_ctl_reg <= `SWREG_CTL_RST;
      shut_reg      <= 2'b11;
      busy_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      rdat_reg      <= rdat_next;
      rval_reg      <= rval_next;
      hrst_reg      <= hrst_next;
      soft_reg      <= soft_next;
      wstb_reg      <= wstb_next;
      wdat_reg      <= wdat_next;
      chan_en_reg   <= chan_en_next;
      clk_slot_reg  <= clk_slot_next;
      dev_cfg_reg   <= dev_cfg_next;
      int_mask_reg  <= int_mask_next;
      swreg_par_reg <= swreg_par_next;
      swreg_ctl_reg <= swreg_ctl_next;
      shut_reg      <= shut_next;
      busy_reg      <= busy_next;
    end
  end

  assign rd_valid         = rval_reg;
  assign rd_data          = rdat_reg;
  assign busy             = busy_reg;
  assign chan_shutdown    = shut_reg;
  assign chan_enable      = sel;
  assign hard_reset_pulse = hrst_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_hard_cmd;
    state_reg == DEC_IDLE && byte_valid && byte_in == `CMD_HARD_RESET && !hrst_reg;
  endsequence

  sequence s_soft_cmd;
    state_reg == DEC_IDLE && byte_valid && byte_in == `CMD_SOFT_RESET && !hrst_reg;
  endsequence

  property p_hard_shutdown;
    @(posedge ref_clk) disable iff (!resetn)
    s_hard_cmd |=> hard_reset_pulse ##2 (chan_shutdown == 2'b11);
  endproperty
  a_hard_shutdown: assert property (p_hard_shutdown) else $error("hard reset left a channel up"); // RQ6

  property p_hard_defaults;
    @(posedge ref_clk) disable iff (!resetn)
    s_hard_cmd |=> ##1 (dev_cfg_reg == `DEV_CFG_RST && chan_en_reg == `CHAN_EN_RST);
  endproperty
  a_hard_defaults: assert property (p_hard_defaults) else $error("defaults not restored"); // RQ7

  property p_soft_keeps_slots;
    @(posedge ref_clk) disable iff (!resetn)
    s_soft_cmd |=> ##1 ($stable(clk_slot_reg) && $stable(tx_slot[0]) && $stable(dev_cfg_reg));
  endproperty
  a_soft_keeps_slots: assert property (p_soft_keeps_slots) else $error("soft reset changed slots"); // RQ3

  property p_soft_unselected;
    @(posedge ref_clk) disable iff (!resetn)
    (s_soft_cmd ##0 !sel[0]) |=> ##1 $stable(lstate[0]);
  endproperty
  a_soft_unselected: assert property (p_soft_unselected) else $error("unselected channel reset"); // RQ2

  property p_soft_disconnect;
    @(posedge ref_clk) disable iff (!resetn)
    (s_soft_cmd ##0 (sel[0] && lstate[0] != LINE_SHUTDOWN)) |=> ##1 lstate[0] == LINE_DISCONNECT;
  endproperty
  a_soft_disconnect: assert property (p_soft_disconnect) else $error("no disconnect"); // RQ4

  property p_read_flag;
    @(posedge ref_clk) disable iff (!resetn)
    (state_reg == DEC_IDLE && byte_valid && byte_in[0] && !hrst_reg) |=> rd_valid && busy;
  endproperty
  a_read_flag: assert property (p_read_flag) else $error("read not answered"); // RQ1

  property p_nop_quiet;
    @(posedge ref_clk) disable iff (!resetn)
    (state_reg == DEC_IDLE && byte_valid && byte_in == `CMD_NO_OP && !hrst_reg)
      |=> !busy && $stable(chan_en_reg) && $stable(rd_data) && !wstb_reg;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-op had an effect"); // RQ17

  property p_enable_write;
    @(posedge ref_clk) disable iff (!resetn)
    (state_reg == DEC_WR_DATA && byte_valid && cmd_reg == `CMD_CHAN_EN_WR && !hrst_reg)
      |=> chan_en_reg == $past(byte_in);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // RQ10

  property p_broadcast;
    @(posedge ref_clk) disable iff (!resetn)
    (wstb_reg && cmd_reg == `CMD_TX_SLOT_WR && sel == 2'b11 && !hrst_reg)
      |=> tx_slot[0] == tx_slot[1];
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("channels differ after write"); // RQ18

  property p_low_read;
    @(posedge ref_clk) disable iff (!resetn)
    (state_reg == DEC_IDLE && byte_valid && byte_in == `CMD_TX_DATA_RD && sel[0] && !hrst_reg)
      |=> rd_data == $past(tx_sample_0);
  endproperty
  a_low_read: assert property (p_low_read) else $error("wrong channel read"); // RQ19

endmodule
`default_nettype wire

// *** cmd_decoder_map.svh ***
// Constants for the voice channel command decoder
`ifndef CMD_DECODER_MAP_SVH
`define CMD_DECODER_MAP_SVH

// ----------------------------------------------------------------
// Command codes (write codes, read is code + 1; CMD_REV_RD and CMD_TX_DATA_RD are read codes)
// ----------------------------------------------------------------
`define CMD_SOFT_RESET    8'h02
`define CMD_HARD_RESET    8'h04
`define CMD_NO_OP         8'h06
`define CMD_TX_SLOT_WR    8'h40
`define CMD_RX_SLOT_WR    8'h42
`define CMD_CLK_SLOT_WR   8'h44
`define CMD_DEV_CFG_WR    8'h46
`define CMD_CHAN_EN_WR    8'h4A
`define CMD_GAINS_WR      8'h50
`define CMD_SYS_STATE_WR  8'h56
`define CMD_INT_MASK_WR   8'h6C
`define CMD_REV_RD        8'h73
`define CMD_TX_DATA_RD    8'hCD
`define CMD_SWREG_PAR_WR  8'hE4
`define CMD_SWREG_CTL_WR  8'hE6

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RW_BIT            0
`define CHAN0_EN_BIT      0
`define CHAN1_EN_BIT      1
`define TX_SLOT_RST0      8'h00
`define TX_SLOT_RST1      8'h01
`define RX_SLOT_RST0      8'h00
`define RX_SLOT_RST1      8'h01
`define CLK_SLOT_RST      8'h00
`define DEV_CFG_RST       8'h8A
`define CHAN_EN_RST       8'h00
`define GAINS_RST         8'h00
`define INT_MASK_RST      8'h00
`define SWREG_PAR_RST     8'h00
`define SWREG_CTL_RST     8'h00
// Identity codes: arbitrary neutral values, not those of any real part
`define REVISION_ID       8'h5A
`define PART_CODE_ID      8'hA5

`endif

// *** cmd_decoder_pkg.sv ***
// Types for the voice channel command decoder
`default_nettype none
package cmd_decoder_pkg;
  typedef enum logic [1:0] {
    LINE_SHUTDOWN,
    LINE_DISCONNECT,
    LINE_ACTIVE,
    LINE_RINGING
  } line_state_type;

  typedef enum {
    DEC_IDLE,
    DEC_WR_DATA,
    DEC_RD_DATA
  } dec_state_type;
endpackage
`default_nettype wire

// *** channel_regs.sv ***
// Per-channel register set: time slots, gains and line state
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_map.svh"
module channel_regs
  import cmd_decoder_pkg::*;
#(
  parameter logic [7:0] TX_SLOT_RST = 8'h00,
  parameter logic [7:0] RX_SLOT_RST = 8'h00
) (
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  input  wire logic           hard_reset,
  input  wire logic           selected,
  input  wire logic           soft_reset,
  input  wire logic           wr_stb,
  input  wire logic [7:0]     wr_cmd,
  input  wire logic [7:0]     wr_data,
  output logic       [7:0]    tx_slot,
  output logic       [7:0]    rx_slot,
  output logic       [7:0]    gains,
  output line_state_type      line_state
);

  logic [7:0]     tx_slot_reg, tx_slot_next;
  logic [7:0]     rx_slot_reg, rx_slot_next;
  logic [7:0]     gains_reg, gains_next;
  line_state_type state_reg, state_next;

  // Next values; writes only land when this channel is selected
  always_comb begin
    tx_slot_next = tx_slot_reg;
    rx_slot_next = rx_slot_reg;
    gains_next   = gains_reg;
    state_next   = state_reg;
    if (hard_reset) begin
      // RQ7: defaults restored
      tx_slot_next = TX_SLOT_RST;
      rx_slot_next = RX_SLOT_RST;
      gains_next   = `GAINS_RST;
      // RQ6: forced to shutdown
      state_next   = LINE_SHUTDOWN;
    end else if (selected && soft_reset) begin
      // RQ4: disconnect unless shut down
      // RQ3: slots left untouched here
      if (state_reg != LINE_SHUTDOWN) begin
        state_next = LINE_DISCONNECT;
      end
    end else if (selected && wr_stb) begin
      // RQ13: per-channel slot storage
      case (wr_cmd)
        `CMD_TX_SLOT_WR: tx_slot_next = wr_data;
        `CMD_RX_SLOT_WR: rx_slot_next = wr_data;
        `CMD_GAINS_WR: gains_next = wr_data;
        `CMD_SYS_STATE_WR: state_next = line_state_type'(wr_data[1:0]);
        default: tx_slot_next = tx_slot_reg;
      endcase
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // RQ5: pin and command give same defaults
      tx_slot_reg <= TX_SLOT_RST;
      rx_slot_reg <= RX_SLOT_RST;
      gains_reg   <= `GAINS_RST;
      state_reg   <= LINE_SHUTDOWN;
    end else begin
      tx_slot_reg <= tx_slot_next;
      rx_slot_reg <= rx_slot_next;
      gains_reg   <= gains_next;
      state_reg   <= state_next;
    end
  end

  assign tx_slot    = tx_slot_reg;
  assign rx_slot    = rx_slot_reg;
  assign gains      = gains_reg;
  assign line_state = state_reg;

endmodule
`default_nettype wire

// *** host_port_model.sv ***
// Host side model that sends command and data bytes and takes read bytes
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic       ref_clk,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_in,
  output var  logic       rd_taken
);
  // ----------------------------------------------------------------
  // Byte driver
  // ----------------------------------------------------------------
  initial begin
    byte_valid = 1'b0;
    byte_in    = 8'h00;
    rd_taken   = 1'b0;
  end

  // Idle byte lines show the inverse of the last byte, so stale data never matches
  task automatic put(input logic [7:0] b, input bit last);
    @(posedge ref_clk);
    byte_valid <= 1'b1;
    byte_in    <= b;
    if (last) begin
      @(posedge ref_clk);
      byte_valid <= 1'b0;
      byte_in    <= ~b;
    end
  endtask

  // only listed codes
  // Lone command byte: soft reset, hard reset, no-op
  task automatic cmd(input logic [7:0] c);
    put(c, 1'b1);
    #1;
  endtask

  // reserved bits zero: callers pass data below 80h
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    put({c[7:1], 1'b0}, 1'b0);
    put(d, 1'b1);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // odd code reads
  // Waits a bounded time for the byte, then hands it back
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    int n;
    put({c[7:1], 1'b1}, 1'b1);
    #1;
    n = 0;
    while (rd_valid !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    @(posedge ref_clk);
    rd_taken <= 1'b1;
    @(posedge ref_clk);
    rd_taken <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// *** voice_channel_command_decoder_bench.sv ***
// Self-checking bench for the voice channel command decoder
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_map.svh"
module voice_channel_command_decoder_bench;
  import cmd_decoder_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn  = 1'b0;
  logic       byte_valid;
  logic [7:0] byte_in;
  logic       rd_taken;
  logic [7:0] tx_sample_0 = 8'h3C;
  logic [7:0] tx_sample_1 = 8'hC3;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       busy;
  logic [1:0] chan_shutdown;
  logic [1:0] chan_enable;
  logic       hard_reset_pulse;
  logic [7:0] d;
  int         failures = 0;
  int         compares = 0;
  int         cycles   = 0;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  voice_channel_command_decoder uut (
    .ref_clk(ref_clk), .resetn(resetn), .byte_valid(byte_valid), .byte_in(byte_in),
    .rd_taken(rd_taken), .tx_sample_0(tx_sample_0), .tx_sample_1(tx_sample_1),
    .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .chan_shutdown(chan_shutdown),
    .chan_enable(chan_enable), .hard_reset_pulse(hard_reset_pulse)
  );

  host_port_model host (
    .ref_clk(ref_clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .byte_valid(byte_valid), .byte_in(byte_in), .rd_taken(rd_taken)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cycle ceiling well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({6'h00, chan_enable}, 8'h00);
    check({6'h00, chan_shutdown}, 8'h03);
    check({7'h00, rd_valid}, 8'h00);
    host.wr(8'h4A, 8'h02);
    host.rd(8'h41, d);
    check(d, `TX_SLOT_RST1);
    host.rd(8'h43, d);
    check(d, `RX_SLOT_RST1);
  endtask

  task automatic t_enable();
    host.wr(8'h4A, 8'h03);
    check({6'h00, chan_enable}, 8'h03);
    host.rd(8'h4B, d);
    check(d, 8'h03);
  endtask

  // Both enabled: writes land in both, reads come from channel 0
  task automatic t_broadcast();
    host.wr(8'h40, 8'h33);
    host.wr(8'h56, 8'h02);
    check({6'h00, chan_shutdown}, 8'h00);
    host.wr(8'h4A, 8'h01);
    host.wr(8'h40, 8'h11);
    host.wr(8'h4A, 8'h03);
    host.rd(8'h41, d);
    check(d, 8'h11);
    host.wr(8'h4A, 8'h02);
    host.rd(8'h41, d);
    check(d, 8'h33);
  endtask

  // Channel 1 shut down first; soft reset must not wake it
  task automatic t_soft();
    host.wr(8'h56, 8'h00);
    check({6'h00, chan_shutdown}, 8'h02);
    host.cmd(`CMD_SOFT_RESET);
    repeat (2) @(posedge ref_clk);
    #1;
    check({6'h00, chan_shutdown}, 8'h02);
    host.wr(8'h4A, 8'h01);
    host.rd(8'h57, d);
    check(d, 8'h02);
    host.wr(8'h4A, 8'h03);
    host.cmd(`CMD_SOFT_RESET);
    repeat (2) @(posedge ref_clk);
    #1;
    check({6'h00, chan_shutdown}, 8'h02);
    host.rd(8'h57, d);
    check(d, 8'h01);
    host.rd(8'h41, d);
    check(d, 8'h11);
    host.rd(8'h4B, d);
    check(d, 8'h03);
  endtask

  // Chip-wide registers: write under one enable, read under the other
  task automatic t_global();
    logic [7:0] codes [5];
    codes = '{`CMD_CLK_SLOT_WR, `CMD_DEV_CFG_WR, `CMD_INT_MASK_WR, `CMD_SWREG_PAR_WR,
              `CMD_SWREG_CTL_WR};
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h4A, 8'h01);
      host.wr(codes[i], 8'h25 + 8'(i));
      host.wr(8'h4A, 8'h02);
      host.rd(codes[i] + 8'h01, d);
      check(d, 8'h25 + 8'(i));
    end
  endtask

  task automatic t_reads();
    host.rd(`CMD_REV_RD, d);
    check(d, `REVISION_ID ^ `PART_CODE_ID);
    host.rd(`CMD_TX_DATA_RD, d);
    check(d, 8'hC3);
    host.wr(8'h4A, 8'h03);
    host.rd(`CMD_TX_DATA_RD, d);
    check(d, 8'h3C);
  endtask

  task automatic t_nop();
    host.cmd(`CMD_NO_OP);
    check({7'h00, busy}, 8'h00);
    check({6'h00, chan_enable}, 8'h03);
    check(rd_data, 8'h3C);
    host.rd(8'h41, d);
    check(d, 8'h11);
  endtask

  // Hard reset command: pulse, all shut down, defaults back
  task automatic t_hard();
    host.cmd(`CMD_HARD_RESET);
    check({7'h00, hard_reset_pulse}, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1;
    check({6'h00, chan_shutdown}, 8'h03);
    check({6'h00, chan_enable}, 8'h00);
    host.wr(8'h4A, 8'h02);
    host.rd(8'h41, d);
    check(d, `TX_SLOT_RST1);
    host.rd(8'h45, d);
    check(d, `CLK_SLOT_RST);
    host.rd(8'h47, d);
    check(d, `DEV_CFG_RST);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_enable();
    t_broadcast();
    t_soft();
    t_global();
    host.wr(8'h4A, 8'h02);
    t_reads();
    t_nop();
    t_hard();
    end_of_test();
  end
endmodule
`default_nettype wire
